// ==== hdl/fadc_pkg.sv ====
// Shared constants for the flash converter timing model.
// Assumes a 100 MHz core_clk on both ends.
package fadc_pkg;
   localparam int          NUM_COMP          = 256;
   localparam int          CODE_W            = 8;
   localparam int          CLK_PERIOD_NS     = 10;
   localparam int          DATA_VALID_NS     = 65;
   localparam int          DATA_VALID_CYC    = (DATA_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          SAMPLE_MAX_NS     = 500;
   localparam int          SAMPLE_MAX_CYC    = SAMPLE_MAX_NS / CLK_PERIOD_NS;
   localparam int          HALF_PERIOD_CYC   = 4;
   localparam int          CAPTURE_WAIT_CYC  = 16;
   localparam logic [7:0]  RESET_CODE        = 8'h00;
   localparam logic [3:0]  DLY_W_MAX         = 4'hF;
endpackage

// ==== hdl/fadc_link_if.sv ====
// Pin bundle between the converter and its capture host.
// Assumes the testbench resolves tri-state data from the enables.
`timescale 1ns/1ps
`default_nettype none
interface fadc_link_if;
   logic        conv_clk;
   logic        clock_polarity_select;
   logic        data_disable_high;
   logic        all_output_enable;
   logic [7:0]  conv_data;
   logic [7:0]  conv_data_oe;
   logic        overflow_flag;
   logic        overflow_oe;
   modport dev  (input conv_clk, clock_polarity_select, data_disable_high, all_output_enable,
                 output conv_data, conv_data_oe, overflow_flag, overflow_oe);
   modport host (output conv_clk, clock_polarity_select, data_disable_high, all_output_enable,
                 input conv_data, conv_data_oe, overflow_flag, overflow_oe);
endinterface
`default_nettype wire

// ==== hdl/fadc_host.sv ====
// Capture host: makes the converter clock by division, double pulses, parks in balance.
// Assumes the converter end on the other side of the interface.
`timescale 1ns/1ps
`default_nettype none
module fadc_host (
   input  wire logic  core_clk,
   input  wire logic  resetn,
   input  wire logic  run,
   input  wire logic  pol_sel,
   input  wire logic  high_disable,
   input  wire logic  out_enable,
   output logic [7:0] cap_data,
   output logic       cap_over,
   output logic       cap_valid,
   fadc_link_if.host  link
);
   typedef struct packed {
      logic [3:0] div;
      logic       clk;
      logic [1:0] pend;
      logic [7:0] dat;
      logic       ovf;
      logic       vld;
      logic [7:0] d1;
      logic [7:0] d2;
      logic       o1;
      logic       o2;
      logic       armed;
      logic [4:0] wait_cnt;
   } fadc_hst_type;
   fadc_hst_type st_r, st_nxt;
   logic bal_lvl;

   // Balance is clock high when select high, else clock low
   assign bal_lvl = pol_sel;

   always_comb begin
      st_nxt     = st_r;
      st_nxt.vld = 1'b0;
      st_nxt.d1  = link.conv_data;
      st_nxt.d2  = st_r.d1;
      st_nxt.o1  = link.overflow_flag;
      st_nxt.o2  = st_r.o1;
      // Capture once the device delay after the last sample end has run out
      if (st_r.wait_cnt != 5'h00) begin
         st_nxt.wait_cnt = st_r.wait_cnt - 5'h01;
         if (st_r.wait_cnt == 5'h01) begin
            st_nxt.dat = st_r.d2;
            st_nxt.ovf = st_r.o2;
            st_nxt.vld = 1'b1;
         end
      end
      if (st_r.pend != 2'd0 || st_r.clk != bal_lvl) begin
         // Half periods stay well under the sample limit
         if (st_r.div == 4'(fadc_pkg::HALF_PERIOD_CYC - 1)) begin
            st_nxt.div = 4'h0;
            st_nxt.clk = ~st_r.clk;
            if (st_r.clk == bal_lvl && st_r.pend != 2'd0) begin
               st_nxt.pend = st_r.pend - 2'd1;
            end
            if (st_r.clk != bal_lvl && st_r.pend == 2'd0 && st_r.armed) begin
               // Second sample end of the pair: its data follows later
               st_nxt.armed    = 1'b0;
               st_nxt.wait_cnt = 5'(fadc_pkg::CAPTURE_WAIT_CYC);
            end
         end else begin
            st_nxt.div = st_r.div + 4'h1;
         end
      end else begin
         st_nxt.div = 4'h0; // Parked in balance
      end
      if (run && st_r.pend == 2'd0 && st_r.wait_cnt == 5'h00) begin
         st_nxt.pend  = 2'd2;
         st_nxt.armed = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign link.conv_clk              = st_r.clk;
   assign link.clock_polarity_select = pol_sel;
   assign link.data_disable_high     = high_disable;
   assign link.all_output_enable     = out_enable;
   assign cap_data                   = st_r.dat;
   assign cap_over                   = st_r.ovf;
   assign cap_valid                  = st_r.vld;
endmodule
`default_nettype wire

// ==== hdl/fadc_dev.sv ====
// Converter end: two-phase clocking, two latch rows, decode, output register, enables.
// Assumes conv_clk and control pins are asynchronous to core_clk; analog in is a level.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - One conversion per converter clock cycle
// - Select high: balance high, sample low
// - Select inverts incoming clock level
// - Select low: rising edge starts sampling
// - Sample end freezes comparators into row one
// - Balance end copies row one to row two
// - Taps above input report high
// - Thermometer decodes to count plus overflow
// - Next sample end loads outputs, delayed
// - Data needs two like-polarity edges
// - Host keeps sampling under 500 ns
// - Host double pulses in intermittent use
// - Host parks indefinitely in balance
// - Short standby only under limit
// - Enable low floats all nine outputs
// - Disable high floats data, overflow driven
// - Overflow above top count transition
// - Straight binary, bit one least significant
module fadc_dev (
   input  wire logic       core_clk,
   input  wire logic       resetn,
   input  wire logic [8:0] analog_level,
   fadc_link_if.dev        link
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------

   typedef struct packed {
      logic [1:0]   ck_s;
      logic [1:0]   ps_s;
      logic [1:0]   dh_s;
      logic [1:0]   oe_s;
      logic [8:0]   an_s1;
      logic [8:0]   an_s2;
      logic         phase;
      logic [255:0] row1;
      logic [255:0] row2;
      logic [8:0]   code;
      logic [8:0]   pipe;
      logic [3:0]   dly;
      logic [7:0]   dat;
      logic         ovf;
      logic [7:0]   dat_oe;
      logic         ovf_oe;
   } fadc_dev_type;

   fadc_dev_type st_r;
   fadc_dev_type st_nxt;
   logic         smp_lvl;
   logic         smp_end;
   logic         bal_end;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------

   // Two-stage shift; only the second stage is read by logic
   function automatic logic [1:0] fadc_sync2(input logic [1:0] s, input logic pin);
      return {s[0], pin};
   endfunction

   // ------------------------------------------------------------
   // Comparator bank
   // ------------------------------------------------------------

   // Tap n trips at level 2n+1 over 512; input in half-LSB steps
   function automatic logic [255:0] fadc_thermo(input logic [8:0] lvl);
      logic [255:0] t;
      t = '0;
      for (int n = 0; n < fadc_pkg::NUM_COMP; n++) begin
         t[n] = (9'(2 * n + 1) > lvl);
      end
      return t;
   endfunction

   // ------------------------------------------------------------
   // Decoder
   // ------------------------------------------------------------

   // Count of low comparators
   function automatic logic [8:0] fadc_count_low(input logic [255:0] t);
      logic [8:0] c;
      c = '0;
      for (int n = 0; n < fadc_pkg::NUM_COMP; n++) begin
         c = c + {8'h00, ~t[n]};
      end
      return c;
   endfunction

   // Count 256 shows as overflow with 255 data
   function automatic logic [8:0] fadc_saturate(input logic [8:0] c);
      logic [8:0] s;
      s = c;
      if (c[8]) begin
         s = 9'h1FF;
      end
      return s;
   endfunction

   function automatic logic [8:0] fadc_decode(input logic [255:0] t);
      return fadc_saturate(fadc_count_low(t));
   endfunction

   // ------------------------------------------------------------
   // Output enables
   // ------------------------------------------------------------

   // All eight data bits follow the disable, as the truth table has it
   function automatic logic [7:0] fadc_dat_drive(input logic en, input logic dis_hi);
      logic [7:0] d;
      d = 8'h00;
      if (en && !dis_hi) begin
         d = 8'hFF;
      end
      return d;
   endfunction

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------

   always_comb begin
      st_nxt       = st_r;

      st_nxt.ck_s  = fadc_sync2(st_r.ck_s, link.conv_clk);
      st_nxt.ps_s  = fadc_sync2(st_r.ps_s, link.clock_polarity_select);
      st_nxt.dh_s  = fadc_sync2(st_r.dh_s, link.data_disable_high);
      st_nxt.oe_s  = fadc_sync2(st_r.oe_s, link.all_output_enable);
      st_nxt.an_s1 = analog_level;
      st_nxt.an_s2 = st_r.an_s1;

      // Sample phase is the clock level flipped by the select
      smp_lvl      = st_r.ck_s[1] ^ st_r.ps_s[1];
      smp_end      = st_r.phase && !smp_lvl;
      bal_end      = !st_r.phase && smp_lvl;
      st_nxt.phase = smp_lvl;

      // Row one follows the input while sampling, frozen after
      if (smp_lvl) begin
         st_nxt.row1 = fadc_thermo(st_r.an_s2);
      end

      // Row two takes row one as balance ends
      if (bal_end) begin
         st_nxt.row2 = st_r.row1;
      end

      st_nxt.code = fadc_decode(st_r.row2);

      // Sample end loads the previous decode, shown after the delay
      if (smp_end) begin
         st_nxt.pipe = st_r.code;
         st_nxt.dly  = 4'(fadc_pkg::DATA_VALID_CYC);
      end else if (st_r.dly != 4'h0) begin
         st_nxt.dly = st_r.dly - 4'h1;
      end

      if (st_r.dly == 4'h1) begin
         st_nxt.dat = st_r.pipe[7:0];
         st_nxt.ovf = st_r.pipe[8];
      end

      st_nxt.ovf_oe = st_r.oe_s[1];
      st_nxt.dat_oe = fadc_dat_drive(st_r.oe_s[1], st_r.dh_s[1]);
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ------------------------------------------------------------
   // Pins
   // ------------------------------------------------------------

   assign link.conv_data     = st_r.dat;
   assign link.conv_data_oe  = st_r.dat_oe;
   assign link.overflow_flag = st_r.ovf;
   assign link.overflow_oe   = st_r.ovf_oe;
endmodule
`default_nettype wire

// ==== verification/fadc_chk_sva.sv ====
// Assertions on the converter link signals.
// Assumes it sits beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module fadc_chk (
   input wire logic       core_clk,
   input wire logic       resetn,
   input wire logic       conv_clk,
   input wire logic       clock_polarity_select,
   input wire logic       data_disable_high,
   input wire logic       all_output_enable,
   input wire logic [7:0] conv_data,
   input wire logic [7:0] conv_data_oe,
   input wire logic       overflow_flag,
   input wire logic       overflow_oe
);
   // ---------
   // Checks
   // ---------
   logic [7:0] idle_r;
   wire        samp = conv_clk ^ clock_polarity_select;
   always_ff @(posedge core_clk or negedge resetn)
      if (!resetn) idle_r <= 8'h00;
      else if ($changed(conv_clk)) idle_r <= 8'h00;
      else if (idle_r != 8'hFF) idle_r <= idle_r + 8'h01;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   AST_EN_LOW: assert property (!all_output_enable [*5] |-> !overflow_oe && conv_data_oe == 8'h00)
      else $error("driven while disabled");
   AST_DIS_HIGH: assert property ((all_output_enable && data_disable_high) [*5]
      |-> overflow_oe && conv_data_oe == 8'h00) else $error("bad high disable");
   AST_DRIVE: assert property ((all_output_enable && !data_disable_high) [*5]
      |-> overflow_oe && conv_data_oe == 8'hFF) else $error("not driven");
   AST_OF_SAT: assert property (overflow_flag |-> conv_data == 8'hFF)
      else $error("overflow without full count");
   AST_LOAD: assert property ($changed({overflow_flag, conv_data}) |-> idle_r <= 8'h0C)
      else $error("load away from clock edge");
   AST_PARK: assert property (($stable(conv_clk) && $stable(clock_polarity_select)) [*8]
      |-> conv_clk == clock_polarity_select) else $error("parked in sample");
   AST_SAMP_MAX: assert property ($rose(samp) |-> ##[1:50] !samp)
      else $error("sample too long");
   AST_HALF: assert property ($changed(conv_clk) |=> $stable(conv_clk) [*3])
      else $error("clock half too short");
endmodule
`default_nettype wire

// ==== verification/tb_flash_adc_digital_timing.sv ====
// Bench for both converter ends joined by the link.
// Assumes design files and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_flash_adc_digital_timing;
   // ---------
   // Bench
   // ---------
   logic        core_clk, resetn, run, pol_sel, high_disable, out_enable, cap_over, cap_valid;
   logic [8:0]  analog_level;
   logic [7:0]  cap_data;
   logic [31:0] lfsr = 32'h7D8F;
   logic [8:0]  exp_q[$];
   logic [8:0]  lvl_tab[5] = '{9'h000, 9'h001, 9'h101, 9'h1FE, 9'h1FF};
   int          n_mismatch = 0;
   int          checks_done = 0;
   fadc_link_if link ();
   fadc_host fadc_host_inst (.core_clk(core_clk), .resetn(resetn), .run(run), .pol_sel(pol_sel),
      .high_disable(high_disable), .out_enable(out_enable), .cap_data(cap_data),
      .cap_over(cap_over), .cap_valid(cap_valid), .link(link));
   fadc_dev fadc_dev_inst (.core_clk(core_clk), .resetn(resetn), .analog_level(analog_level),
      .link(link));
   fadc_chk fadc_chk_inst (.core_clk(core_clk), .resetn(resetn), .conv_clk(link.conv_clk),
      .clock_polarity_select(link.clock_polarity_select),
      .data_disable_high(link.data_disable_high), .all_output_enable(link.all_output_enable),
      .conv_data(link.conv_data), .conv_data_oe(link.conv_data_oe),
      .overflow_flag(link.overflow_flag), .overflow_oe(link.overflow_oe));
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic cmp_code(input logic [8:0] got, input logic [8:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_oe(input logic [8:0] got, input logic [8:0] exp);
      cmp_code(got, exp);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic convert(input logic [8:0] lvl);
      logic [9:0] c;
      c = ({1'b0, lvl} + 10'h001) >> 1;
      analog_level = lvl;
      exp_q.push_back(c[8] ? 9'h1FF : {1'b0, c[7:0]});
      run = 1'b1;
      @(posedge core_clk) #1 run = 1'b0;
      for (int i = 0; i < 80 && exp_q.size() != 0; i++) @(posedge core_clk) #1;
   endtask
   always @(posedge core_clk)
      if (cap_valid === 1'b1) cmp_code({cap_over, cap_data}, exp_q.pop_front());
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      #50000;
      n_mismatch++;
      test_done();
   end
   initial begin
      {resetn, run, pol_sel, high_disable} = 4'h0;
      out_enable = 1'b1;
      analog_level = 9'h000;
      repeat (6) @(posedge core_clk);
      #1 resetn = 1'b1;
      for (int k = 0; k < 14; k++) begin
         lfsr = lfsr_next(lfsr);
         pol_sel = k[2];
         convert(k < 5 ? lvl_tab[k] : lfsr[8:0]);
      end
      for (int m = 0; m < 3; m++) begin
         out_enable = m != 0;
         high_disable = m == 2;
         repeat (5) @(posedge core_clk);
         #1 cmp_oe({link.overflow_oe, link.conv_data_oe}, {m != 0, {8{m == 1}}});
      end
      test_done();
   end
endmodule
`default_nettype wire
